// *** shared/mad_defs.svh ***
// Offsets, opcodes, field limits and reset values of the decoder.
// Assumes an APB bus with byte addresses carried on paddr[7:0].
`ifndef MAD_DEFS_SVH
`define MAD_DEFS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define MAD_OFF_CMD 8'h00
`define MAD_OFF_STAT 8'h04
`define MAD_OFF_RESP 8'h08
`define MAD_OFF_CTRL 8'h0c
`define MAD_OFF_FREQ 8'h10
`define MAD_OFF_RATE 8'h14
`define MAD_OFF_EXC 8'h18
`define MAD_OFF_REF 8'h1c
`define MAD_OFF_SEL 8'h20
`define MAD_OFF_STRAP 8'h24
// ****************************************************************
// Status register fields
// ****************************************************************
`define MAD_ST_AVAIL 0
`define MAD_ST_BUSY 1
`define MAD_ST_REJECT 2
`define MAD_ST_BADOP 3
`define MAD_ST_CNT_LO 4
// ****************************************************************
// Opcodes and command lengths
// ****************************************************************
`define MAD_OP_QALARM 16'h2408
`define MAD_OP_CTRL 16'h2600
`define MAD_OP_CFG 16'h2601
`define MAD_CTRL_BYTES 5'h01
`define MAD_CFG_BYTES 5'h17
`define MAD_ALM_BYTES 3'h5
// ****************************************************************
// Field limits
// ****************************************************************
`define MAD_MAX_CTRL 8'h02
`define MAD_MAX_MODE 8'h03
`define MAD_MAX_MASK 8'h02
`define MAD_MAX_REFSRC 8'h02
`define MAD_MAX_MOD 8'h04
`define MAD_MAX_FEC 8'h16
`define MAD_IF_LO 32'd50000000
`define MAD_IF_HI 32'd180000000
`define MAD_LB_LO 32'd950000000
`define MAD_LB_HI 32'd1750000000
`define MAD_CLK_LO 32'd256000
`define MAD_CLK_HI 32'd10000000
`define MAD_CLK_STEP 32'd8000
// ****************************************************************
// Reset values
// ****************************************************************
`define MAD_CTRL_RST 8'h00
`endif

// *** shared/mad_pkg.sv ***
// Types shared by the decoder: parser states, alarm inputs, config.
// Assumes mad_defs.svh supplies the numeric constants.
package mad_pkg;
   typedef enum logic [2:0] {
      MAD_OPHI = 3'h1,
      MAD_OPLO = 3'h2,
      MAD_PAY = 3'h4
   } mad_state_t;

   typedef struct packed {
      logic [7:0] mod_alarm;
      logic [7:0] activity;
      logic [7:0] drop_status;
      logic [7:0] common1;
      logic [7:0] common2;
   } mad_alarm_t;

   // Field order matches the wire order, first byte in the top bits.
   typedef struct packed {
      logic [7:0] mode;
      logic [31:0] if_freq;
      logic [15:0] strap;
      logic [7:0] filter_mask;
      logic [31:0] data_rate;
      logic [31:0] ext_exc_clk;
      logic [31:0] ext_ref;
      logic [7:0] ref_source;
      logic [7:0] modulation;
      logic [7:0] fec;
   } mad_cfg_t;
endpackage : mad_pkg

// *** core/mad_decoder.sv ***
// Remote monitor-and-control decoder for the modulator, APB slave.
// Assumes synchronous alarm inputs and a one-clock system on pclk.
`timescale 1ns/1ns
`include "mad_defs.svh"

module mad_decoder (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Alarm sources
   input wire mad_pkg::mad_alarm_t alarm_in,
   input wire logic lband_variant,
   // Decoded configuration
   output mad_pkg::mad_cfg_t cfg,
   output logic [7:0] ctrl_mode,
   output logic cfg_update
);

   // ****************************************************************
   // APB decode
   // ****************************************************************
   wire logic setup_ph = psel & ~penable;
   wire logic xfer = psel & penable & pready;
   wire logic wr_xfer = xfer & pwrite;
   wire logic rd_xfer = xfer & ~pwrite;
   wire logic hit_cmd = paddr == `MAD_OFF_CMD;
   wire logic hit_stat = paddr == `MAD_OFF_STAT;
   wire logic hit_resp = paddr == `MAD_OFF_RESP;
   wire logic hit_ctrl = paddr == `MAD_OFF_CTRL;
   wire logic hit_freq = paddr == `MAD_OFF_FREQ;
   wire logic hit_rate = paddr == `MAD_OFF_RATE;
   wire logic hit_exc = paddr == `MAD_OFF_EXC;
   wire logic hit_ref = paddr == `MAD_OFF_REF;
   wire logic hit_sel = paddr == `MAD_OFF_SEL;
   wire logic hit_strap = paddr == `MAD_OFF_STRAP;
   wire logic mapped = hit_cmd | hit_stat | hit_resp | hit_ctrl |
      hit_freq | hit_rate | hit_exc | hit_ref | hit_sel | hit_strap;
   wire logic byte_in = wr_xfer & hit_cmd;
   wire logic [7:0] din = pwdata[7:0];

   // ****************************************************************
   // State
   // ****************************************************************
   mad_pkg::mad_state_t state_reg;
   mad_pkg::mad_state_t state_next;
   logic [7:0] op_hi_reg;
   logic [4:0] left_reg;
   logic [15:0] opcode_reg;
   logic [175:0] shadow_reg;
   logic [7:0] resp_mem [0:4];
   logic [2:0] resp_cnt_reg;
   logic [2:0] resp_idx_reg;
   logic reject_reg;
   logic badop_reg;

   // ****************************************************************
   // Alarm byte assembly
   // ****************************************************************
   // The inputs already sit at their documented bit positions; here
   // only spare and reserved bits are forced to zero so that a stray
   // source level never reaches the remote controller.
   wire logic [7:0] alm_mod = alarm_in.mod_alarm;
   wire logic [7:0] alm_act = {2'h0, alarm_in.activity[5:0]};
   wire logic [7:0] alm_drop = alarm_in.drop_status;
   wire logic [7:0] alm_com1 =
      {2'h0, alarm_in.common1[5:4], 1'b0, alarm_in.common1[2:0]};
   wire logic [7:0] alm_com2 = {5'h00, alarm_in.common2[2:0]};

   // ****************************************************************
   // Byte parser
   // ****************************************************************
   wire logic [15:0] opcode_full = {op_hi_reg, din};
   wire logic is_qalarm = opcode_full == `MAD_OP_QALARM;
   wire logic is_ctrl = opcode_full == `MAD_OP_CTRL;
   wire logic is_cfg = opcode_full == `MAD_OP_CFG;
   wire logic last_byte = (state_reg == mad_pkg::MAD_PAY) &&
      (left_reg == 5'h01);
   wire logic opcode_done = byte_in && (state_reg == mad_pkg::MAD_OPLO);
   wire logic payload_done = byte_in && last_byte;

   always_comb begin
      state_next = state_reg;
      if (byte_in) begin
         unique case (state_reg)
            mad_pkg::MAD_OPHI: state_next = mad_pkg::MAD_OPLO;
            mad_pkg::MAD_OPLO: begin
               state_next = (is_ctrl | is_cfg) ? mad_pkg::MAD_PAY :
                  mad_pkg::MAD_OPHI;
            end
            mad_pkg::MAD_PAY: begin
               if (last_byte) begin
                  state_next = mad_pkg::MAD_OPHI;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Field checks
   // ****************************************************************
   // Fields arrive most significant byte first, so the shift register
   // leaves the first byte in the top bits, as the struct expects.
   mad_pkg::mad_cfg_t cfg_new;
   assign cfg_new = {shadow_reg, din};
   wire logic ok_mode = cfg_new.mode <= `MAD_MAX_MODE;
   wire logic ok_if_std = (cfg_new.if_freq >= `MAD_IF_LO) &&
      (cfg_new.if_freq <= `MAD_IF_HI);
   wire logic ok_if_lb = (cfg_new.if_freq >= `MAD_LB_LO) &&
      (cfg_new.if_freq <= `MAD_LB_HI);
   wire logic ok_freq = lband_variant ? ok_if_lb : ok_if_std;
   wire logic ok_mask = cfg_new.filter_mask <= `MAD_MAX_MASK;
   // The 8 kHz step check costs a constant-divisor remainder; the
   // area is accepted so that off-grid clocks are never applied.
   wire logic ok_exc = (cfg_new.ext_exc_clk >= `MAD_CLK_LO) &&
      (cfg_new.ext_exc_clk <= `MAD_CLK_HI) &&
      ((cfg_new.ext_exc_clk % `MAD_CLK_STEP) == 32'h0);
   wire logic ok_ref = (cfg_new.ext_ref >= `MAD_CLK_LO) &&
      (cfg_new.ext_ref <= `MAD_CLK_HI) &&
      ((cfg_new.ext_ref % `MAD_CLK_STEP) == 32'h0);
   wire logic ok_src = cfg_new.ref_source <= `MAD_MAX_REFSRC;
   wire logic ok_modn = cfg_new.modulation <= `MAD_MAX_MOD;
   wire logic ok_fec = cfg_new.fec <= `MAD_MAX_FEC;
   wire logic cfg_ok = ok_mode & ok_freq & ok_mask & ok_exc & ok_ref &
      ok_src & ok_modn & ok_fec;
   wire logic ctrl_ok = din <= `MAD_MAX_CTRL;
   wire logic is_cfg_cmd = opcode_reg == `MAD_OP_CFG;
   wire logic cfg_commit = payload_done & is_cfg_cmd & cfg_ok;
   wire logic ctrl_commit = payload_done & ~is_cfg_cmd & ctrl_ok;
   wire logic bad_value = payload_done &
      (is_cfg_cmd ? ~cfg_ok : ~ctrl_ok);
   wire logic bad_opcode = opcode_done & ~is_qalarm & ~is_ctrl & ~is_cfg;

   // ****************************************************************
   // Response queue
   // ****************************************************************
   wire logic resp_avail = resp_cnt_reg != 3'h0;
   wire logic resp_pop = rd_xfer & hit_resp & resp_avail;
   wire logic resp_load = opcode_done & is_qalarm;
   wire logic [7:0] resp_head = resp_mem[resp_idx_reg];
   wire logic w1c = wr_xfer & hit_stat;

   // ****************************************************************
   // Read data
   // ****************************************************************
   wire logic [31:0] stat_word = {24'h0, 1'b0, resp_cnt_reg, badop_reg,
      reject_reg, state_reg != mad_pkg::MAD_OPHI, resp_avail};
   wire logic [31:0] sel_word = {cfg.fec, cfg.modulation, cfg.ref_source,
      cfg.filter_mask};
   wire logic [31:0] rd_word =
      hit_stat ? stat_word :
      hit_resp ? {24'h0, resp_avail ? resp_head : 8'h00} :
      hit_ctrl ? {24'h0, ctrl_mode} :
      hit_freq ? cfg.if_freq :
      hit_rate ? cfg.data_rate :
      hit_exc ? cfg.ext_exc_clk :
      hit_ref ? cfg.ext_ref :
      hit_sel ? sel_word :
      hit_strap ? {8'h0, cfg.strap, cfg.mode} : 32'h0;

   // ****************************************************************
   // Bus side flops
   // ****************************************************************
   // One wait-free access cycle: pready rises for the access phase that
   // follows each setup phase, with read data already registered.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_ph;
         pslverr <= setup_ph & ~mapped;
         if (setup_ph) begin
            prdata <= pwrite ? 32'h0 : rd_word;
         end
      end
   end

   // ****************************************************************
   // Parser flops
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= mad_pkg::MAD_OPHI;
         op_hi_reg <= 8'h00;
         opcode_reg <= 16'h0000;
         left_reg <= 5'h00;
         shadow_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (byte_in && state_reg == mad_pkg::MAD_OPHI) begin
            op_hi_reg <= din;
         end
         if (opcode_done) begin
            opcode_reg <= opcode_full;
            left_reg <= is_cfg ? `MAD_CFG_BYTES : `MAD_CTRL_BYTES;
         end else if (byte_in && state_reg == mad_pkg::MAD_PAY) begin
            left_reg <= left_reg - 5'h01;
            shadow_reg <= {shadow_reg[167:0], din};
         end
      end
   end

   // ****************************************************************
   // Applied settings
   // ****************************************************************
   // A rejected command leaves the previous settings untouched.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= '0;
         ctrl_mode <= `MAD_CTRL_RST;
         cfg_update <= 1'b0;
      end else begin
         cfg_update <= cfg_commit;
         if (cfg_commit) begin
            cfg <= cfg_new;
         end
         if (ctrl_commit) begin
            ctrl_mode <= din;
         end
      end
   end

   // ****************************************************************
   // Sticky error flags, set wins over a write-one clear
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reject_reg <= 1'b0;
         badop_reg <= 1'b0;
      end else begin
         reject_reg <= bad_value |
            (reject_reg & ~(w1c & pwdata[`MAD_ST_REJECT]));
         badop_reg <= bad_opcode |
            (badop_reg & ~(w1c & pwdata[`MAD_ST_BADOP]));
      end
   end

   // ****************************************************************
   // Alarm snapshot and readout
   // ****************************************************************
   // The five bytes are frozen at the query so one response is
   // coherent even if the alarm sources move while it is read out.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp_cnt_reg <= 3'h0;
         resp_idx_reg <= 3'h0;
      end else if (resp_load) begin
         resp_cnt_reg <= `MAD_ALM_BYTES;
         resp_idx_reg <= 3'h0;
      end else if (resp_pop) begin
         resp_cnt_reg <= resp_cnt_reg - 3'h1;
         resp_idx_reg <= resp_idx_reg + 3'h1;
      end
   end

   always_ff @(posedge pclk) begin
      if (resp_load) begin
         resp_mem[0] <= alm_mod;
         resp_mem[1] <= alm_act;
         resp_mem[2] <= alm_drop;
         resp_mem[3] <= alm_com1;
         resp_mem[4] <= alm_com2;
      end
   end

endmodule : mad_decoder

// *** dv/mad_decoder_props.sv ***
// Checker for the decoder: bus timing, readback and field limits.
// Assumes it is bound to mad_decoder and sees only its ports.
`timescale 1ns/1ns
module mad_decoder_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Alarms and decoded settings
   input wire mad_pkg::mad_alarm_t alarm_in,
   input wire logic lband_variant,
   input wire mad_pkg::mad_cfg_t cfg,
   input wire logic [7:0] ctrl_mode,
   input wire logic cfg_update
);
   // ****************
   // Helpers
   // ****************
   function automatic logic clk_ok(input logic [31:0] v);
      return v >= 32'd256000 && v <= 32'd10000000 && v % 32'd8000 == 0;
   endfunction : clk_ok
   wire wr_cmd = psel && penable && pready && pwrite && paddr == 8'h00;
   wire rd_ok = pready && !pwrite;
   wire [31:0] f = cfg.if_freq;
   wire lb_ok = f >= 32'd950000000 && f <= 32'd1750000000;
   wire if_ok = f >= 32'd50000000 && f <= 32'd180000000;
   wire band_ok = lband_variant ? lb_ok : if_ok;
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_ready_zero: assert property (psel && !penable |=> pready && penable)
      else $error("no answer in first access cycle");
   chk_ready_only: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   chk_err_unmapped: assert property (pready && paddr > 8'h24 |->
      pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   chk_err_mapped: assert property (pready && paddr <= 8'h24 &&
      paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped access refused");
   chk_ctrl_read: assert property (rd_ok && paddr == 8'h0c &&
      $stable(ctrl_mode) |-> prdata == {24'h0, ctrl_mode})
      else $error("control mode readback wrong");
   chk_freq_read: assert property (rd_ok && paddr == 8'h10 &&
      $stable(cfg) |-> prdata == cfg.if_freq)
      else $error("frequency readback wrong");
   chk_ctrl_range: assert property (ctrl_mode <= 8'h02)
      else $error("control mode out of range");
   chk_cfg_codes: assert property (cfg.mode <= 8'h03 &&
      cfg.filter_mask <= 8'h02 && cfg.ref_source <= 8'h02 &&
      cfg.modulation <= 8'h04 && cfg.fec <= 8'h16)
      else $error("applied code out of range");
   chk_ctrl_cause: assert property ($changed(ctrl_mode) |->
      $past(wr_cmd) || $past(wr_cmd, 2))
      else $error("control mode changed without a command");
   chk_cfg_ranges: assert property (cfg_update |-> band_ok &&
      clk_ok(cfg.ext_exc_clk) && clk_ok(cfg.ext_ref))
      else $error("applied value out of range");
   cover property (cfg_update);
   cover property (pready && pslverr);
   cover property ($changed(ctrl_mode));
endmodule : mad_decoder_props

// *** dv/mad_host_model.sv ***
// APB master standing in for the remote controller.
// Assumes an APB slave on pclk that may add wait states.
`timescale 1ns/1ns
module mad_host_model (
   // Clock
   input wire logic pclk,
   // APB master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic pready,
   // Raised when a transfer never completes
   output logic hang
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hang = 1'b0;
   end
   // Released data is inverted so a slave cannot live on stale values.
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 64);
      hang <= !pready;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : mad_host_model

// *** dv/mad_decoder_bench.sv ***
// Self-checking bench for the decoder: queries, commands, refusals.
// Assumes mad_host_model as bus master and mad_decoder_props bound.
`timescale 1ns/1ns
module mad_decoder_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, lband_variant;
   logic cfg_update, hang;
   logic [7:0] paddr, ctrl_mode;
   logic [31:0] pwdata, prdata;
   mad_pkg::mad_alarm_t alarm_in;
   mad_pkg::mad_cfg_t cfg, c, b;
   logic [32:0] exp_q[$];
   int err_total = 0;
   int num_checks = 0;
   int upd_total = 0;
   int seed = 32'h8d5d;
   always #25 pclk = ~pclk;
   mad_decoder u_mad_decoder (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .alarm_in(alarm_in), .lband_variant(lband_variant), .cfg(cfg),
      .ctrl_mode(ctrl_mode), .cfg_update(cfg_update));
   mad_host_model u_mad_host_model (.pclk(pclk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .hang(hang));
   // ****************
   // Tasks
   // ****************
   task check(input logic [183:0] seen, input logic [183:0] exp,
              input string m);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : check
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task wr(input logic [7:0] a, input logic [31:0] d);
      u_mad_host_model.xfer(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      u_mad_host_model.xfer(1'b0, a, 32'h0);
   endtask : rd
   task send_cfg(input mad_pkg::mad_cfg_t v);
      wr(8'h00, 32'h26);
      wr(8'h00, 32'h01);
      for (int i = 0; i < 23; i++)
         wr(8'h00, {24'h0, v[183 - 8 * i -: 8]});
   endtask : send_cfg
   // ****************
   // Monitor and hang guard
   // ****************
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (exp_q.size() == 0)
            check(1'b1, 1'b0, "unexpected read");
         else
            check({pslverr, prdata}, exp_q.pop_front(), "read data");
      end
   end
   always @(posedge pclk) begin
      if (cfg_update === 1'b1)
         upd_total++;
   end
   always @(posedge hang) begin
      err_total++;
      report_and_stop;
   end
   // ****************
   // Sequence
   // ****************
   initial begin
      alarm_in <= '0;
      lband_variant <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h0c, 33'h0);
      rd(8'h04, 33'h0);
      rd(8'h08, 33'h0);
      check(cfg, '0, "config after reset");
      $display("test reset done");
      repeat (3) begin
         alarm_in <= {$random(seed), 8'($random(seed))};
         wr(8'h00, 32'h24);
         wr(8'h00, 32'h08);
         rd(8'h04, 33'h51);
         rd(8'h08, {25'h0, alarm_in.mod_alarm});
         rd(8'h08, {25'h0, alarm_in.activity & 8'h3f});
         rd(8'h08, {25'h0, alarm_in.drop_status});
         rd(8'h08, {25'h0, alarm_in.common1 & 8'h37});
         rd(8'h08, {25'h0, alarm_in.common2 & 8'h07});
      end
      rd(8'h04, 33'h0);
      $display("test alarm query done");
      for (int v = 0; v < 4; v++) begin
         wr(8'h00, 32'h26);
         wr(8'h00, 32'h00);
         wr(8'h00, 32'(v));
         rd(8'h0c, 33'(v < 3 ? v : 2));
         rd(8'h04, v < 3 ? 33'h0 : 33'h4);
      end
      wr(8'h04, 32'h0c);
      $display("test control mode done");
      for (int k = 0; k < 2; k++) begin
         lband_variant <= k[0];
         c.mode = 8'({$random(seed)} % 4);
         c.if_freq = k ? 950000000 + {$random(seed)} % 800000001
                       : 32'd180000000;
         c.strap = 16'($random(seed));
         c.filter_mask = 8'({$random(seed)} % 3);
         c.data_rate = $random(seed);
         c.ext_exc_clk = 256000 + 8000 * ({$random(seed)} % 1219);
         c.ext_ref = k ? 32'd10000000 : 32'd256000;
         c.ref_source = 8'({$random(seed)} % 3);
         c.modulation = 8'({$random(seed)} % 5);
         c.fec = k ? 8'h16 : 8'({$random(seed)} % 23);
         send_cfg(c);
         rd(8'h04, 33'h0);
         check(cfg, c, "config applied");
         rd(8'h10, {1'b0, c.if_freq});
         rd(8'h14, {1'b0, c.data_rate});
         rd(8'h18, {1'b0, c.ext_exc_clk});
         rd(8'h1c, {1'b0, c.ext_ref});
         rd(8'h24, {9'h0, c.strap, c.mode});
         for (int j = 0; j < 5; j++) begin
            b = c;
            case (j)
               0: b.fec = 8'h17;
               1: b.modulation = 8'h05;
               2: b.ext_ref = c.ext_ref - 32'd8;
               3: b.if_freq = k ? 32'd1750000001 : 32'd180000001;
               default: b.mode = 8'h04;
            endcase
            send_cfg(b);
            rd(8'h04, 33'h4);
            wr(8'h04, 32'h04);
         end
         check(cfg, c, "config kept after refusal");
      end
      for (int i = 0; i < 23; i++) begin
         c.fec = 8'(i);
         c.modulation = 8'(i % 5);
         c.ref_source = 8'(i % 3);
         c.filter_mask = 8'(i % 3);
         send_cfg(c);
         rd(8'h20, {1'b0, c.fec, c.modulation, c.ref_source,
            c.filter_mask});
      end
      $display("test configuration done");
      wr(8'h00, 32'h12);
      rd(8'h04, 33'h2);
      wr(8'h00, 32'h34);
      rd(8'h04, 33'h8);
      wr(8'h04, 32'h08);
      rd(8'h04, 33'h0);
      wr(8'h00, 32'h12);
      wr(8'h00, 32'h34);
      rd(8'h40, 33'h100000000);
      $display("test refusals done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check(cfg, '0, "config after mid-run reset");
      rd(8'h0c, 33'h0);
      rd(8'h04, 33'h0);
      $display("test mid-run reset done");
      repeat (3) @(posedge pclk);
      check(33'(exp_q.size()), 33'h0, "reads left unanswered");
      check(upd_total, 25, "config update pulses");
      report_and_stop;
   end
endmodule : mad_decoder_bench
bind mad_decoder mad_decoder_props u_mad_decoder_props (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .alarm_in(alarm_in), .lband_variant(lband_variant),
   .cfg(cfg), .ctrl_mode(ctrl_mode), .cfg_update(cfg_update));
